/* File: verilog/port_event_flags_and_masks.sv */
// event latching, clear-on-read aliases, summary and alert output for
// a four-channel group
// assumes a front end that turns serial bus transfers into single-cycle
// command strobes and takes the read byte one cycle later
//
// Behaviour
// [RL1] detection mask bit 3 set lets detection events pull the alert low
// [RL2] disconnect mask bit 2 set lets disconnect events pull the alert low
// [RL3] power good mask bit 1 set lets power good changes pull alert low
// [RL4] power enable mask bit 0 set lets power enable changes pull alert low
// [RL5] event bits are active high, sticky, channel one in low bit of nibble
// [RL6] read at 02h returns power event byte, flags untouched
// [RL7] read at 03h returns same power byte, then clears it
// [RL8] clear-read alias returns plain-read data, only adds clearing
// [RL9] clear-read of the register causing the alert releases the alert
// [RL10] power byte: high nibble power good changes, low nibble enable changes
// [RL11] any set event bit shows in its interrupt summary bit
// [RL12] read at 04h returns detection event byte unchanged
// [RL13] read at 05h returns detection byte and clears it
// [RL14] a channel's detection flags clear when that channel turns off
// [RL15] class bits set every class cycle, or only on class change if selected
// [RL16] detect bits set every detection cycle, or only on change if selected
// [RL17] alert mask is read/write at 01h, zero bit blocks that event
// [RL18] summary bits follow events regardless of masks
// [RL19] global alert enable must be set for any alert
// [RL20] each summary bit except disconnect is the OR of its four channel flags
// [RL21] alert low when enabled and any summary bit is set and unmasked; the class summary bit never pulls it low
// [RL22] an event arriving during its clear-read stays latched
module port_event_flags_and_masks (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register command port
    input wire event_flags_pkg::cmd_s cmd,
    output logic [7:0] rd_data_r,
    output logic rd_valid_r,
    // configuration bits held in the general mask register elsewhere
    input wire logic global_alert_enable,
    input wire logic class_change_only_select,
    input wire logic detect_change_only_select,
    // disconnect summary from the fault event register elsewhere
    input wire logic disconnect_any,
    // channel status, index 0 is channel one
    input wire event_flags_pkg::chan_in_s [3:0] chan_in,
    // summary and alert
    output logic [7:0] alert_summary_r,
    output logic alert_n_r
);

    // event flag storage
    logic [7:0] power_event_r;
    logic [7:0] power_event_nxt;
    logic [7:0] detect_event_r;
    logic [7:0] detect_event_nxt;

    // low half of the alert mask
    logic [3:0] mask_low_r;

    // decoded command strobes
    logic rd_strobe;
    logic wr_strobe;
    logic clr_power;
    logic clr_detect;

    // per-channel event pulses and the bytes assembled from them
    event_flags_pkg::chan_evt_s [3:0] evt;
    logic [7:0] power_set;
    logic [7:0] detect_set;
    logic [7:0] detect_off_clr;

    // summary terms
    logic sum_pgood;
    logic sum_penable;
    logic sum_class;
    logic sum_detect;
    logic [7:0] summary_now;
    logic alert_active;

    ////////////////////////////////////////////////////////////////////////
    // per-channel detectors and bit placement, one channel per pass
    genvar ch;
    generate
        for (ch = 0; ch < event_flags_pkg::NUM_CHAN; ch++) begin : g_chan
            chan_event_detect u_det (
                .mclk(mclk),
                .srst(srst),
                .class_change_only_select(class_change_only_select),
                .detect_change_only_select(detect_change_only_select),
                .chan(chan_in[ch]),
                .evt(evt[ch])
            );

            // channel one lands in the low bit of each nibble
            assign power_set[event_flags_pkg::PGOOD_BASE + ch] = evt[ch].pgood_chg; // [RL5] [RL10]
            assign power_set[event_flags_pkg::PENABLE_BASE + ch] = evt[ch].penable_chg; // [RL10]
            assign detect_set[event_flags_pkg::CLASS_BASE + ch] = evt[ch].class_evt; // [RL5]
            assign detect_set[event_flags_pkg::DETECT_BASE + ch] = evt[ch].detect_evt;

            // turning a channel off wipes both of its detection bits
            assign detect_off_clr[event_flags_pkg::CLASS_BASE + ch] = evt[ch].turned_off; // [RL14]
            assign detect_off_clr[event_flags_pkg::DETECT_BASE + ch] = evt[ch].turned_off;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // command decode; writes to anything but the mask are dropped
    assign rd_strobe = cmd.valid & ~cmd.write;
    assign wr_strobe = cmd.valid & cmd.write;
    assign clr_power = rd_strobe & (cmd.code == event_flags_pkg::CMD_POWER_EVENT_CLR); // [RL7]
    assign clr_detect = rd_strobe & (cmd.code == event_flags_pkg::CMD_DETECT_EVENT_CLR); // [RL13]

    ////////////////////////////////////////////////////////////////////////
    // next flag values: clear first, then OR in new events so a set in the
    // clearing cycle survives; the host will see it on its next read
    always_comb begin
        power_event_nxt = clr_power ? event_flags_pkg::EVENT_RESET : power_event_r; // [RL8]
        power_event_nxt = power_event_nxt | power_set; // [RL5] [RL22]
        detect_event_nxt = clr_detect ? event_flags_pkg::EVENT_RESET : detect_event_r;
        detect_event_nxt = detect_event_nxt & ~detect_off_clr; // [RL14]
        detect_event_nxt = detect_event_nxt | detect_set; // [RL22]
    end

    // power event flags
    always_ff @(posedge mclk) begin
        if (srst) begin
            power_event_r <= event_flags_pkg::EVENT_RESET;
        end else begin
            power_event_r <= power_event_nxt;
        end
    end

    // detection event flags
    always_ff @(posedge mclk) begin
        if (srst) begin
            detect_event_r <= event_flags_pkg::EVENT_RESET;
        end else begin
            detect_event_r <= detect_event_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alert mask, only the low nibble is kept; upper bits read as zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_low_r <= event_flags_pkg::MASK_LOW_RESET;
        end else if (wr_strobe && cmd.code == event_flags_pkg::CMD_ALERT_MASK) begin
            mask_low_r <= cmd.wdata[3:0]; // [RL17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data is the flag value before any clear of the same cycle, so
    // both aliases of a register return the identical byte
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_data_r <= event_flags_pkg::UNMAPPED_READ;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_strobe;
            if (rd_strobe) begin
                case (cmd.code)
                    event_flags_pkg::CMD_ALERT_MASK: begin
                        rd_data_r <= {4'h0, mask_low_r}; // [RL17]
                    end
                    event_flags_pkg::CMD_POWER_EVENT: begin
                        rd_data_r <= power_event_r; // [RL6]
                    end
                    event_flags_pkg::CMD_POWER_EVENT_CLR: begin
                        rd_data_r <= power_event_r; // [RL7] [RL8]
                    end
                    event_flags_pkg::CMD_DETECT_EVENT: begin
                        rd_data_r <= detect_event_r; // [RL12]
                    end
                    event_flags_pkg::CMD_DETECT_EVENT_CLR: begin
                        rd_data_r <= detect_event_r; // [RL13] [RL8]
                    end
                    default: begin
                        rd_data_r <= event_flags_pkg::UNMAPPED_READ;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // summary bits are plain ORs of the stored flags, never masked
    assign sum_pgood = |power_event_r[event_flags_pkg::PGOOD_BASE +: 4]; // [RL20] [RL11]
    assign sum_penable = |power_event_r[event_flags_pkg::PENABLE_BASE +: 4]; // [RL20]
    assign sum_class = |detect_event_r[event_flags_pkg::CLASS_BASE +: 4]; // [RL20]
    assign sum_detect = |detect_event_r[event_flags_pkg::DETECT_BASE +: 4]; // [RL20]

    // summary byte in interrupt register layout; fault bits live elsewhere
    always_comb begin
        summary_now = event_flags_pkg::SUMMARY_RESET;
        summary_now[event_flags_pkg::SUM_CLASS_BIT] = sum_class; // [RL11]
        summary_now[event_flags_pkg::SUM_DETECT_BIT] = sum_detect;
        summary_now[event_flags_pkg::SUM_DISCONNECT_BIT] = disconnect_any;
        summary_now[event_flags_pkg::SUM_PGOOD_BIT] = sum_pgood;
        summary_now[event_flags_pkg::SUM_PENABLE_BIT] = sum_penable;
    end

    // masking gates only the alert, not the summary
    always_ff @(posedge mclk) begin
        if (srst) begin
            alert_summary_r <= event_flags_pkg::SUMMARY_RESET;
        end else begin
            alert_summary_r <= summary_now; // [RL18]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alert term; a clear-read empties the flags so the alert releases
    // on its own once no other unmasked source remains
    always_comb begin
        alert_active =
            (sum_detect & mask_low_r[event_flags_pkg::MASK_DETECT_BIT]) | // [RL1]
            (disconnect_any & mask_low_r[event_flags_pkg::MASK_DISCONNECT_BIT]) | // [RL2]
            (sum_pgood & mask_low_r[event_flags_pkg::MASK_PGOOD_BIT]) | // [RL3]
            (sum_penable & mask_low_r[event_flags_pkg::MASK_PENABLE_BIT]); // [RL4]
        alert_active = alert_active & global_alert_enable; // [RL19]
    end

    // active-low alert, released high during reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            alert_n_r <= 1'b1;
        end else begin
            alert_n_r <= ~alert_active; // [RL21] [RL9]
        end
    end

endmodule // port_event_flags_and_masks

/* File: verilog/event_flags_pkg.sv */
// package for the per-channel event flag and alert mask block
// assumes one 10 MHz clock and a command-code register port in front of it
package event_flags_pkg;

    localparam int NUM_CHAN = 4;

    // command codes of the register port
    localparam logic [7:0] CMD_ALERT_MASK = 8'h01;
    localparam logic [7:0] CMD_POWER_EVENT = 8'h02;
    localparam logic [7:0] CMD_POWER_EVENT_CLR = 8'h03;
    localparam logic [7:0] CMD_DETECT_EVENT = 8'h04;
    localparam logic [7:0] CMD_DETECT_EVENT_CLR = 8'h05;

    // value returned for an unmapped command code
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // reset values
    localparam logic [7:0] EVENT_RESET = 8'h00;
    localparam logic [3:0] MASK_LOW_RESET = 4'h0;
    localparam logic [7:0] SUMMARY_RESET = 8'h00;
    localparam logic [3:0] RESULT_RESET = 4'h0;

    // mask bit positions in the alert mask byte
    localparam int MASK_DETECT_BIT = 3;
    localparam int MASK_DISCONNECT_BIT = 2;
    localparam int MASK_PGOOD_BIT = 1;
    localparam int MASK_PENABLE_BIT = 0;

    // field bases inside the event bytes (channel n at base + n)
    localparam int PGOOD_BASE = 4;
    localparam int PENABLE_BASE = 0;
    localparam int CLASS_BASE = 4;
    localparam int DETECT_BASE = 0;

    // summary bit positions in the interrupt summary byte
    localparam int SUM_CLASS_BIT = 4;
    localparam int SUM_DETECT_BIT = 3;
    localparam int SUM_DISCONNECT_BIT = 2;
    localparam int SUM_PGOOD_BIT = 1;
    localparam int SUM_PENABLE_BIT = 0;

    // per-channel status and cycle results from the port state machines
    typedef struct packed {
        logic on;               // channel is switched on
        logic power_good;       // power good status level
        logic power_enable;     // power enable status level
        logic class_done;       // one-cycle pulse, classification cycle finished
        logic [3:0] class_val;  // measured class, valid with class_done
        logic det_done;         // one-cycle pulse, detection cycle finished
        logic [3:0] det_val;    // detection result, valid with det_done
    } chan_in_s;

    // one command from the serial register front end
    typedef struct packed {
        logic valid;            // one-cycle strobe
        logic write;            // 1 = write, 0 = read
        logic [7:0] code;       // command code
        logic [7:0] wdata;      // write data byte
    } cmd_s;

    // event pulses produced for one channel
    typedef struct packed {
        logic pgood_chg;
        logic penable_chg;
        logic class_evt;
        logic detect_evt;
        logic turned_off;
    } chan_evt_s;

endpackage

/* File: verilog/chan_event_detect.sv */
// per-channel event detection: status changes and cycle results
// assumes inputs synchronous to mclk and done strobes one cycle wide
module chan_event_detect (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // selects for change-only reporting
    input wire logic class_change_only_select,
    input wire logic detect_change_only_select,
    // channel status
    input wire event_flags_pkg::chan_in_s chan,
    // event pulses
    output event_flags_pkg::chan_evt_s evt
);

    logic pg_r;
    logic pe_r;
    logic on_r;
    logic [3:0] class_last_r;
    logic [3:0] det_last_r;

    ////////////////////////////////////////////////////////////////////////
    // previous levels for edge detection
    always_ff @(posedge mclk) begin
        if (srst) begin
            pg_r <= 1'b0;
            pe_r <= 1'b0;
            on_r <= 1'b0;
        end else begin
            pg_r <= chan.power_good;
            pe_r <= chan.power_enable;
            on_r <= chan.on;
        end
    end

    // last reported results, kept so change-only mode can compare
    always_ff @(posedge mclk) begin
        if (srst) begin
            class_last_r <= event_flags_pkg::RESULT_RESET;
            det_last_r <= event_flags_pkg::RESULT_RESET;
        end else begin
            if (chan.class_done) begin
                class_last_r <= chan.class_val;
            end
            if (chan.det_done) begin
                det_last_r <= chan.det_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event pulses; first result after reset compares against zero
    always_comb begin
        evt.pgood_chg = chan.power_good ^ pg_r;
        evt.penable_chg = chan.power_enable ^ pe_r;
        evt.class_evt = chan.class_done &
            (~class_change_only_select | (chan.class_val != class_last_r)); // [RL15]
        evt.detect_evt = chan.det_done &
            (~detect_change_only_select | (chan.det_val != det_last_r)); // [RL16]
        evt.turned_off = on_r & ~chan.on;
    end

endmodule // chan_event_detect

/* File: tb/port_event_flags_and_masks_properties.sv */
// concurrent checks on the ports of the event flag and alert block
// assumes one mclk domain and a bind from the bench top file
module port_event_flags_and_masks_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register command port
    input wire event_flags_pkg::cmd_s cmd,
    input wire logic [7:0] rd_data_r,
    input wire logic rd_valid_r,
    // event sources
    input wire logic global_alert_enable,
    input wire logic disconnect_any,
    input wire event_flags_pkg::chan_in_s [3:0] chan_in,
    // summary and alert
    input wire logic [7:0] alert_summary_r,
    input wire logic alert_n_r
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////////
    // register port answers
    property p_read_answer;
        cmd.valid && !cmd.write |=> rd_valid_r;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read strobe got no answer");
    property p_answer_cause;
        rd_valid_r |-> $past(cmd.valid && !cmd.write);
    endproperty
    a_answer_cause: assert property (p_answer_cause)
        else $error("read answer without a read strobe");
    property p_write_silent;
        cmd.valid && cmd.write |=> !rd_valid_r;
    endproperty
    a_write_silent: assert property (p_write_silent)
        else $error("write produced a read answer");
    // read data must hold between answers so a slow host can pick it up
    property p_data_hold;
        !rd_valid_r |-> $stable(rd_data_r);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("read data moved without an answer");

    ////////////////////////////////////////////////////////////////////////////
    // summary and alert
    property p_summary_upper;
        alert_summary_r[7:5] == 3'h0;
    endproperty
    a_summary_upper: assert property (p_summary_upper)
        else $error("unused summary bits set");
    property p_disc_summary;
        $rose(disconnect_any) |-> ##[1:3] alert_summary_r[2];
    endproperty
    a_disc_summary: assert property (p_disc_summary)
        else $error("disconnect did not reach summary");
    property p_pgood_summary;
        $changed(chan_in[0].power_good) |-> ##[1:3] alert_summary_r[1];
    endproperty
    a_pgood_summary: assert property (p_pgood_summary)
        else $error("power good change did not reach summary");
    property p_enable_gate;
        !global_alert_enable [*2] |-> alert_n_r;
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("alert active with global enable low");
    // alert and summary register on the same edge, so the past copy is only extra margin
    property p_alert_cause;
        !alert_n_r |-> (|alert_summary_r[3:0]) || (|$past(alert_summary_r[3:0]));
    endproperty
    a_alert_cause: assert property (p_alert_cause)
        else $error("alert active with no summary source");
endmodule // port_event_flags_and_masks_properties

/* File: tb/host_model.sv */
// host side model issuing single-byte register commands
// assumes the device answers a read one edge after the strobe
module host_model (
    // clock
    input wire logic mclk,
    // command strobe towards the device
    output event_flags_pkg::cmd_s cmd,
    // read answer
    input wire logic [7:0] rd_data_r,
    input wire logic rd_valid_r
);
    timeunit 1ns;
    timeprecision 1ns;

    initial cmd = '0;

    // one-cycle strobe, answer sampled mid-cycle once settled
    task xfer(input logic wr, input logic [7:0] code, input logic [7:0] wd,
            output logic [7:0] d);
        @(posedge mclk);
        cmd <= {1'b1, wr, code, wd};
        @(posedge mclk);
        cmd <= '0;
        @(negedge mclk);
        d = rd_valid_r ? rd_data_r : 8'hxx; // a missing answer never matches
    endtask
endmodule // host_model

/* File: tb/port_event_flags_and_masks_bench.sv */
// self-checking bench for the event flag and alert block
// assumes host_model and the properties checker compiled before it
module port_event_flags_and_masks_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk = 1'b0;
    logic srst = 1'b1;
    event_flags_pkg::cmd_s cmd;
    logic [7:0] rd_data_r;
    logic [7:0] alert_summary_r;
    logic rd_valid_r;
    logic alert_n_r;
    logic global_alert_enable = 1'b0;
    logic class_sel = 1'b0;
    logic detect_sel = 1'b0;
    logic disconnect_any = 1'b0;
    event_flags_pkg::chan_in_s [3:0] chan_in = {4{13'h1000}};
    logic [7:0] pw [4] = '{8'h01, 8'h10, 8'h00, 8'h00};
    logic [7:0] v;
    int bad_count = 0;
    int n_checks = 0;

    // 10 MHz clock
    always #50 mclk = ~mclk;

    port_event_flags_and_masks dut (.mclk(mclk), .srst(srst), .cmd(cmd),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .global_alert_enable(global_alert_enable), .class_change_only_select(class_sel),
        .detect_change_only_select(detect_sel), .disconnect_any(disconnect_any),
        .chan_in(chan_in), .alert_summary_r(alert_summary_r), .alert_n_r(alert_n_r));
    host_model host (.mclk(mclk), .cmd(cmd), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rdc(input logic [7:0] code, input logic [7:0] exp);
        host.xfer(1'b0, code, 8'h00, v);
        chk(v, exp);
    endtask
    task wr(input logic [7:0] code, input logic [7:0] wd);
        host.xfer(1'b1, code, wd, v);
    endtask
    // ends mid-cycle so registered outputs are looked at once settled
    task idle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    // one classification or detection result pulse
    task cyc(input int ch, input logic cls, input logic [3:0] val);
        @(posedge mclk);
        chan_in[ch].class_done <= cls;
        chan_in[ch].class_val <= val;
        chan_in[ch].det_done <= !cls;
        chan_in[ch].det_val <= val;
        @(posedge mclk);
        chan_in[ch].class_done <= 1'b0;
        chan_in[ch].det_done <= 1'b0;
    endtask
    // raise one alert source on channel one: enable, good, disconnect, detect
    task fire(input int i);
        @(posedge mclk);
        case (i)
            0: chan_in[0].power_enable <= !chan_in[0].power_enable;
            1: chan_in[0].power_good <= !chan_in[0].power_good;
            2: disconnect_any <= 1'b1;
            default: cyc(0, 1'b0, 4'h3);
        endcase
    endtask
    task end_sim;
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge mclk);
        bad_count++;
        end_sim;
    end

    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rdc(8'h01, 8'h00);
        wr(8'h03, 8'hff);
        rdc(8'h02, 8'h00);
        rdc(8'h04, 8'h00);
        rdc(8'h10, 8'h00);
        wr(8'h01, 8'hff);
        rdc(8'h01, 8'h0f);
        @(posedge mclk);
        chan_in[1].power_good <= 1'b1;
        chan_in[3].power_enable <= 1'b1;
        global_alert_enable <= 1'b1;
        rdc(8'h02, 8'h28);
        rdc(8'h02, 8'h28);
        rdc(8'h03, 8'h28);
        rdc(8'h02, 8'h00);
        // each source with its mask bit clear, then set
        for (int i = 0; i < 4; i++) begin
            for (int m = 0; m < 2; m++) begin
                wr(8'h01, 8'(m << i));
                fire(i);
                idle(3);
                chk(alert_summary_r, 8'(1 << i));
                chk({7'h00, alert_n_r}, {7'h00, m == 0});
                @(posedge mclk);
                disconnect_any <= 1'b0;
                rdc(8'h03, pw[i]);
                rdc(8'h05, (i == 3) ? 8'h01 : 8'h00);
                idle(3);
                chk({7'h00, alert_n_r}, 8'h01);
            end
        end
        @(posedge mclk);
        global_alert_enable <= 1'b0;
        wr(8'h01, 8'h0f);
        fire(1);
        idle(3);
        chk({7'h00, alert_n_r}, 8'h01);
        @(posedge mclk);
        global_alert_enable <= 1'b1;
        idle(3);
        chk({7'h00, alert_n_r}, 8'h00);
        rdc(8'h03, 8'h10);
        // event in the same cycle as the clear-read survives
        fire(0);
        fork
            rdc(8'h03, 8'h01);
            begin
                @(posedge mclk);
                chan_in[2].power_good <= 1'b1;
            end
        join
        rdc(8'h02, 8'h40);
        // every cycle, then change-only reporting, for detect and class
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            class_sel <= 1'b0;
            detect_sel <= 1'b0;
            cyc(k * 3, k == 1, 4'h5);
            idle(1);
            chk(alert_summary_r, k ? 8'h12 : 8'h0a);
            rdc(8'h05, k ? 8'h80 : 8'h01);
            @(posedge mclk);
            class_sel <= 1'b1;
            detect_sel <= 1'b1;
            cyc(k * 3, k == 1, 4'h5);
            rdc(8'h04, 8'h00);
            cyc(k * 3, k == 1, 4'h6);
            rdc(8'h05, k ? 8'h80 : 8'h01);
        end
        // switching a channel off drops its class and detect flags, not its power flags
        @(posedge mclk);
        detect_sel <= 1'b0;
        cyc(1, 1'b0, 4'h9);
        cyc(1, 1'b1, 4'h9);
        rdc(8'h04, 8'h22);
        @(posedge mclk);
        chan_in[1].on <= 1'b0;
        chan_in[1].power_good <= 1'b0;
        rdc(8'h04, 8'h00);
        rdc(8'h03, 8'h60);
        end_sim;
    end
endmodule // port_event_flags_and_masks_bench

bind port_event_flags_and_masks port_event_flags_and_masks_properties props (
    .mclk(mclk), .srst(srst), .cmd(cmd), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .global_alert_enable(global_alert_enable), .disconnect_any(disconnect_any),
    .chan_in(chan_in), .alert_summary_r(alert_summary_r), .alert_n_r(alert_n_r));
